/* logic/dbgptr_bank.sv */
/*
 * Debug pointer register bank of a memory access port. It holds the
 * read-only pointer that tells a debugger where the debug registers
 * or the component lookup table sit, answers register reads at the
 * two pointer offsets, and classifies transfer addresses on a
 * dedicated debug connection.
 * Assumes the access-port register requests are synchronous to
 * clk_sys and that the tie-off inputs are static after reset.
 */
// Summary of operation
// - small layout gives one read-only word at F8
// - large layout adds high word at F0
// - small layout high location reads zero
// - low word bits 31..12 carry address
// - high word carries address bits 63..32
// - low word bits 11..2 read zero
// - format bit reads one in current layout
// - bit zero tells whether entry exists
// - pointer is a non-secure address
// - access attributes reset suitable for tables
// - multi-page component points to last page
// - several components point to lookup table
// - dedicated link splits map, bit 31 debugger
// - segmented design sets pointer bit 31
// - components should sit in one low half
// - legacy layout banned with large addressing
// - legacy absent entry reads all ones
// - legacy layout format zero, address kept
`timescale 1ns/1ps

module dbgptr_bank
    import dbgptr_pkg::*;
#(
    parameter bit LARGE_ADDR    = 1'b0,
    parameter bit LEGACY_FMT    = 1'b0,
    parameter bit DEDICATED_SEG = 1'b0
)
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // access-port register requests
    input  wire logic                 ap_req,
    input  wire logic                 ap_write,
    input  wire logic [AP_ADDR_W-1:0] ap_addr,
    input  wire logic [WORD_W-1:0]    ap_wdata,
    output logic                      ap_ready,
    output logic                      ap_hit,
    output logic [WORD_W-1:0]         ap_rdata,
    // tie-off description of the debug components
    input  wire logic                 tie_entry_present,
    input  wire logic                 tie_multi_comp,
    input  wire logic [PAGE_W-1:0]    tie_table_page,
    input  wire logic [PAGE_W-1:0]    tie_comp_page,
    input  wire logic [PAGES_W-1:0]   tie_comp_pages,
    // transfer address of the dedicated connection
    input  wire logic                 xfer_valid,
    input  wire logic [WORD_W-1:0]    xfer_addr,
    output logic                      seg_debug_access,
    output logic                      seg_system_access,
    output logic [WORD_W-2:0]         seg_local_addr,
    // pointer status
    output logic                      ptr_valid,
    output logic                      ptr_nonsecure,
    output logic                      ptr_placement_warn,
    output logic [WORD_W-1:0]         ptr_word_low,
    output logic [WORD_W-1:0]         ptr_word_high,
    // control/status word attribute defaults
    output logic [PROT_W-1:0]         csw_prot_default,
    output logic [TYPE_W-1:0]         csw_type_default
);

    // ****************************************************************
    // decoding helpers
    // ****************************************************************

    // word-aligned offset match; low two address bits never decode
    function automatic logic offset_match(
        input logic [AP_ADDR_W-1:0] addr,
        input logic [AP_ADDR_W-1:0] offset
    );
        offset_match = (addr[AP_ADDR_W-1:2] == offset[AP_ADDR_W-1:2]);
    endfunction

    // ****************************************************************
    // layout options
    // ****************************************************************
    wire logic use_large;
    wire logic use_legacy;
    wire logic use_segments;

    assign use_large = LARGE_ADDR;

    // legacy layout is never honoured together with large addressing
    assign use_legacy = LEGACY_FMT && !LARGE_ADDR;

    // segmenting only applies to the 32-bit pointer
    assign use_segments = DEDICATED_SEG && !LARGE_ADDR;

    // ****************************************************************
    // tie-off capture sequence
    // ****************************************************************
    dbgptr_state_t state;
    dbgptr_state_t next_state;

    // captured copies of the tie-offs
    logic                cap_present;
    logic                cap_multi;
    logic [PAGE_W-1:0]   cap_table_page;
    logic [PAGE_W-1:0]   cap_comp_page;
    logic [PAGES_W-1:0]  cap_comp_pages;

    // sequence: reset, one capture cycle, then run for good
    always_comb begin
        case (state)
            DBGPTR_ST_RESET: begin
                next_state = DBGPTR_ST_CAPTURE;
            end
            DBGPTR_ST_CAPTURE: begin
                next_state = DBGPTR_ST_RUN;
            end
            DBGPTR_ST_RUN: begin
                next_state = DBGPTR_ST_RUN;
            end
            default: begin
                next_state = DBGPTR_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= DBGPTR_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    wire logic do_capture;

    assign do_capture = (state == DBGPTR_ST_CAPTURE);

    // straps are sampled once after release, never under reset,
    // so a later wiggle on a tie-off cannot move the pointer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cap_present    <= 1'b0;
            cap_multi      <= 1'b0;
            cap_table_page <= '0;
            cap_comp_page  <= '0;
            cap_comp_pages <= '0;
        end else if (do_capture) begin
            cap_present    <= tie_entry_present;
            cap_multi      <= tie_multi_comp;
            cap_table_page <= tie_table_page;
            cap_comp_page  <= tie_comp_page;
            cap_comp_pages <= tie_comp_pages;
        end
    end

    // ****************************************************************
    // target page selection
    // ****************************************************************
    wire logic [PAGES_W-1:0] pages_less_one;
    wire logic [PAGE_W-1:0]  comp_last_page;
    wire logic [PAGE_W-1:0]  chosen_page;
    logic      [PAGE_W-1:0]  target_page;

    // a page count of zero is read as a single page
    assign pages_less_one = (cap_comp_pages == '0) ? '0 :
                            cap_comp_pages - 4'h1;

    // a wide component is found through its final page
    assign comp_last_page = cap_comp_page +
                            {{(PAGE_W-PAGES_W){1'b0}},
                             pages_less_one};

    // several components are listed by the lookup table
    assign chosen_page = cap_multi ? cap_table_page :
                         comp_last_page;

    // segmented connection: pointer lands in the debugger half
    always_comb begin
        target_page = chosen_page;
        if (use_segments) begin
            target_page[SEG_PAGE_BIT] = 1'b1;
        end
    end

    // ****************************************************************
    // word assembly
    // ****************************************************************
    wire logic [WORD_W-1:0] built_low;
    wire logic [WORD_W-1:0] built_high;

    dbgptr_word_build u_word_build (
        .large_addr    (use_large),
        .legacy_fmt    (use_legacy),
        .target_page   (target_page),
        .entry_present (cap_present),
        .word_low      (built_low),
        .word_high     (built_high)
    );

    // ****************************************************************
    // placement check
    // ****************************************************************
    wire logic above_low_4gb;
    wire logic split_halves;
    wire logic placement_warn;

    // a target beyond 4GB cannot be reached by 32-bit masters
    assign above_low_4gb = |target_page[PAGE_W-1:20];

    // table and component in different 2GB halves
    assign split_halves = cap_multi &&
        (cap_table_page[SEG_PAGE_BIT] != cap_comp_page[SEG_PAGE_BIT]);

    // advisory only: the pointer is still published as tied
    assign placement_warn = cap_present &&
                            (above_low_4gb || split_halves);

    // ****************************************************************
    // pointer words and status
    // ****************************************************************
    // words load once and then hold; nothing else writes them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr_word_low       <= WORD_RESET;
            ptr_word_high      <= WORD_RESET;
            ptr_valid          <= 1'b0;
            ptr_placement_warn <= 1'b0;
        end else if (state == DBGPTR_ST_RUN && !ptr_valid) begin
            ptr_word_low       <= built_low;
            ptr_word_high      <= built_high;
            ptr_valid          <= 1'b1;
            ptr_placement_warn <= placement_warn;
        end
    end

    // pointer is always a non-secure address; attribute defaults
    // must let the first table read go out without a setup write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr_nonsecure    <= 1'b1;
            csw_prot_default <= CSW_PROT_RESET;
            csw_type_default <= CSW_TYPE_RESET;
        end else begin
            ptr_nonsecure    <= 1'b1;
            csw_prot_default <= CSW_PROT_RESET;
            csw_type_default <= CSW_TYPE_RESET;
        end
    end

    // ****************************************************************
    // register access
    // ****************************************************************
    wire logic              hit_low;
    wire logic              hit_high;
    wire logic              hit_any;
    wire logic [WORD_W-1:0] read_word;
    wire logic              unused_wdata;

    assign hit_low  = offset_match(ap_addr, PTR_LOW_OFFSET);
    assign hit_high = offset_match(ap_addr, PTR_HIGH_OFFSET);
    assign hit_any  = hit_low || hit_high;

    // high location reads zero unless the large layout is built
    assign read_word = ap_write ? WORD_RESET :
                       hit_low  ? ptr_word_low :
                       (hit_high && use_large) ? ptr_word_high :
                       WORD_RESET;

    // write data is accepted and dropped on purpose
    assign unused_wdata = ^ap_wdata;

    // one answer per request, a cycle later; writes change nothing
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ap_ready <= 1'b0;
            ap_hit   <= 1'b0;
            ap_rdata <= WORD_RESET;
        end else begin
            ap_ready <= ap_req;
            ap_hit   <= ap_req && hit_any;
            ap_rdata <= ap_req ? read_word : WORD_RESET;
        end
    end

    // ****************************************************************
    // dedicated connection segmentation
    // ****************************************************************
    wire logic xfer_debug_half;

    // bit 31 splits the aliased map into two 2GB halves
    assign xfer_debug_half = xfer_addr[SEG_ADDR_BIT];

    // without segmenting every transfer counts as a debugger one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            seg_debug_access  <= 1'b0;
            seg_system_access <= 1'b0;
            seg_local_addr    <= '0;
        end else begin
            seg_debug_access  <= xfer_valid &&
                                 (!use_segments || xfer_debug_half);
            seg_system_access <= xfer_valid && use_segments &&
                                 !xfer_debug_half;
            seg_local_addr    <= xfer_valid ?
                                 xfer_addr[WORD_W-2:0] : '0;
        end
    end

    // identity words at pointer+FF0 are fetched by the debugger
    // through the transfer address; a missing component simply
    // faults there and the debugger carries on

endmodule

/* logic/dbgptr_word_build.sv */
/*
 * Combinational builder of the two pointer words from the captured
 * page address, the presence bit and the layout options.
 * Assumes its inputs are stable register outputs of the bank.
 */
`timescale 1ns/1ps

module dbgptr_word_build
    import dbgptr_pkg::*;
(
    // layout options
    input  wire logic                 large_addr,
    input  wire logic                 legacy_fmt,
    // pointer content
    input  wire logic [PAGE_W-1:0]    target_page,
    input  wire logic                 entry_present,
    // built words
    output wire logic [WORD_W-1:0]    word_low,
    output wire logic [WORD_W-1:0]    word_high
);

    // ****************************************************************
    // low word
    // ****************************************************************
    wire logic [19:0]       low_page;
    wire logic [WORD_W-1:0] low_current;
    wire logic [WORD_W-1:0] low_legacy;

    // address bits 31..12, low twelve bits implied zero
    assign low_page = target_page[19:0];

    // current layout: reserved zero, format one, presence flag
    assign low_current = {low_page,
                          10'h000,
                          1'b1,
                          entry_present};

    // legacy: whole-word marker when nothing present
    assign low_legacy = entry_present ?
                        {low_page, PAGE_OFFSET_Z} :
                        ABSENCE_MARKER;

    assign word_low = legacy_fmt ? low_legacy : low_current;

    // ****************************************************************
    // high word
    // ****************************************************************
    // only the large layout owns the high location
    assign word_high = large_addr ?
                       target_page[PAGE_W-1:20] :
                       WORD_RESET;

endmodule

/* shared/dbgptr_pkg.sv */
/*
 * Package for the debug pointer register bank: access-port offsets,
 * field positions of the pointer words, reset values and the states
 * of the tie-off capture sequence.
 * Assumes it is compiled before every file under logic/.
 */
package dbgptr_pkg;

    // ****************************************************************
    // access-port register space
    // ****************************************************************
    localparam logic [7:0]  PTR_HIGH_OFFSET = 8'hF0;
    localparam logic [7:0]  PTR_LOW_OFFSET  = 8'hF8;
    localparam int          AP_ADDR_W       = 8;
    localparam int          WORD_W          = 32;

    // ****************************************************************
    // pointer word layout
    // ****************************************************************
    localparam int          PRESENT_BIT     = 0;
    localparam int          FORMAT_BIT      = 1;
    localparam int          RSV_LSB         = 2;
    localparam int          RSV_MSB         = 11;
    localparam int          PAGE_LSB        = 12;
    localparam int          PAGE_W          = 52;
    localparam int          SEG_PAGE_BIT    = 19;
    localparam int          SEG_ADDR_BIT    = 31;
    localparam int          PAGES_W         = 4;
    localparam logic [31:0] ABSENCE_MARKER  = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_RESET      = 32'h00000000;
    localparam logic [11:0] PAGE_OFFSET_Z   = 12'h000;

    // ****************************************************************
    // access attribute defaults for the control/status word
    // ****************************************************************
    localparam int          PROT_W          = 7;
    localparam int          TYPE_W          = 4;
    localparam logic [6:0]  CSW_PROT_RESET  = 7'h03;
    localparam logic [3:0]  CSW_TYPE_RESET  = 4'h0;

    // tie-off capture sequence
    typedef enum logic [1:0] {
        DBGPTR_ST_RESET,
        DBGPTR_ST_CAPTURE,
        DBGPTR_ST_RUN
    } dbgptr_state_t;

endpackage

/* verification/dbgptr_bank_tb.sv */
/*
 * Testbench of the pointer bank in the 64-bit layout: reset with
 * several tie-off descriptions, then reads and writes.
 * Assumes the debugger model and the checker are compiled first.
 */
`timescale 1ns/1ps

module dbgptr_bank_tb;
    import dbgptr_pkg::*;

    logic                 clk_sys = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 ap_req, ap_write, ap_ready, ap_hit;
    logic [AP_ADDR_W-1:0] ap_addr;
    logic [WORD_W-1:0]    ap_wdata, ap_rdata, ptr_word_low, ptr_word_high;
    logic                 tie_present = 1'b0;
    logic                 tie_multi = 1'b0;
    logic [PAGE_W-1:0]    tie_table = '0;
    logic [PAGE_W-1:0]    tie_comp = '0;
    logic [PAGES_W-1:0]   tie_pages = '0;
    logic                 ptr_valid, ptr_nonsecure, ptr_warn;
    logic [PROT_W-1:0]    csw_prot_default;
    logic [TYPE_W-1:0]    csw_type_default;
    int                   num_errors = 0;
    int                   num_checks = 0;
    int                   cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    // segmentation is for 32-bit builds, so its inputs rest
    dbgptr_bank #(.LARGE_ADDR(1'b1)) dbgptr_bank_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .ap_req(ap_req),
        .ap_write(ap_write), .ap_addr(ap_addr), .ap_wdata(ap_wdata),
        .ap_ready(ap_ready), .ap_hit(ap_hit), .ap_rdata(ap_rdata),
        .tie_entry_present(tie_present), .tie_multi_comp(tie_multi),
        .tie_table_page(tie_table), .tie_comp_page(tie_comp),
        .tie_comp_pages(tie_pages), .xfer_valid(1'b0),
        .xfer_addr(32'h00000000), .seg_debug_access(),
        .seg_system_access(), .seg_local_addr(), .ptr_valid(ptr_valid),
        .ptr_nonsecure(ptr_nonsecure), .ptr_placement_warn(ptr_warn),
        .ptr_word_low(ptr_word_low), .ptr_word_high(ptr_word_high),
        .csw_prot_default(csw_prot_default),
        .csw_type_default(csw_type_default));

    dbgptr_dbg_model dbgptr_dbg_model_i (
        .clk_sys(clk_sys), .ap_req(ap_req), .ap_write(ap_write),
        .ap_addr(ap_addr), .ap_wdata(ap_wdata), .ap_ready(ap_ready),
        .ap_hit(ap_hit), .ap_rdata(ap_rdata));

    // ************************************
    // compares and closing
    // ************************************
    task automatic cmp_word(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a whole run needs about a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            $display("MISMATCH timeout expected 1999 seen %0d", cycles);
            end_of_test();
        end
    end

    // one request with its answer compared
    task automatic req_chk(input string what, input logic [7:0] a,
        input logic wr, input logic [31:0] exp, input logic exp_hit);
        logic [31:0] rd;
        logic        hit, rdy;
        dbgptr_dbg_model_i.access(wr, a, 32'hFFFFFFFF, rd, hit, rdy);
        cmp_bit({what, " ready"}, 1'b1, rdy);
        cmp_bit({what, " hit"}, exp_hit, hit);
        cmp_word(what, exp, rd);
    endtask

    // reset with a tie-off description, then read and write it
    task automatic run_case(input string nm, input logic pres, multi,
        input logic [51:0] tp, cp, input logic [3:0] np);
        logic [51:0] pg;
        logic [31:0] lo;
        pg = multi ? tp : cp + (np == 4'h0 ? 52'h0 : 52'(np) - 52'h1);
        lo = {pg[19:0], 10'h000, 1'b1, pres};
        reset_n = 1'b0;
        tie_present = pres;
        tie_multi = multi;
        tie_table = tp;
        tie_comp = cp;
        tie_pages = np;
        repeat (5) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        req_chk("early low", 8'hF8, 1'b0, 32'h00000000, 1'b1);
        @(posedge clk_sys);
        #1 cmp_bit("loaded", 1'b1, ptr_valid);
        cmp_bit("warn", pres && ((|pg[51:20]) || (multi && (tp[19] != cp[19]))), ptr_warn);
        req_chk("low", 8'hF8, 1'b0, lo, 1'b1);
        req_chk("low alias", 8'hFB, 1'b0, lo, 1'b1);
        req_chk("high", 8'hF0, 1'b0, pg[51:20], 1'b1);
        req_chk("gap", 8'hF4, 1'b0, 32'h00000000, 1'b0);
        req_chk("wr low", 8'hF8, 1'b1, 32'h00000000, 1'b1);
        req_chk("wr high", 8'hF0, 1'b1, 32'h00000000, 1'b1);
        req_chk("low kept", 8'hF8, 1'b0, lo, 1'b1);
        req_chk("high kept", 8'hF0, 1'b0, pg[51:20], 1'b1);
        $display("test %s done", nm);
    endtask

    // ************************************
    // main sequence
    // ************************************
    initial begin
        run_case("single", 1'b1, 1'b0, 52'h0, 52'h123456789ABC0, 4'h3);
        run_case("table", 1'b1, 1'b1, 52'h00A5A5F0F0F0F, 52'hFFFFF, 4'h2);
        run_case("absent", 1'b0, 1'b0, 52'h0, 52'h0000080001, 4'h1);
        run_case("no count", 1'b1, 1'b0, 52'h0, 52'h00000000FFFFF, 4'h0);
        cmp_bit("nonsecure", 1'b1, ptr_nonsecure);
        cmp_word("prot", 32'(CSW_PROT_RESET), 32'(csw_prot_default));
        cmp_word("type", 32'(CSW_TYPE_RESET), 32'(csw_type_default));
        end_of_test();
    end
endmodule

bind dbgptr_bank dbgptr_monitor #(
    .LARGE_ADDR(LARGE_ADDR),
    .LEGACY_FMT(LEGACY_FMT)
) dbgptr_monitor_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .ap_req(ap_req),
    .ap_write(ap_write), .ap_addr(ap_addr), .ap_ready(ap_ready),
    .ap_hit(ap_hit), .ap_rdata(ap_rdata), .ptr_valid(ptr_valid),
    .ptr_nonsecure(ptr_nonsecure), .ptr_word_low(ptr_word_low),
    .ptr_word_high(ptr_word_high), .csw_prot_default(csw_prot_default),
    .csw_type_default(csw_type_default)
);

/* verification/dbgptr_dbg_model.sv */
/*
 * Debugger side model: issues single register requests to the bank.
 * Assumes one caller at a time and the one-cycle answer of the bank.
 */
`timescale 1ns/1ps

module dbgptr_dbg_model
    import dbgptr_pkg::*;
(
    // clock
    input  wire logic                 clk_sys,
    // request side
    output logic                      ap_req,
    output logic                      ap_write,
    output logic [AP_ADDR_W-1:0]      ap_addr,
    output logic [WORD_W-1:0]         ap_wdata,
    // answer side
    input  wire logic                 ap_ready,
    input  wire logic                 ap_hit,
    input  wire logic [WORD_W-1:0]    ap_rdata
);
    initial begin
        ap_req   = 1'b0;
        ap_write = 1'b0;
        ap_addr  = 8'h00;
        ap_wdata = 32'h00000000;
    end

    // identity words sit 0xFF0 above the pointed page
    function automatic logic [63:0] ident_addr(input logic [31:0] lo, hi);
        return {hi, lo[31:12], 12'h000} + 64'h0000000000000FF0;
    endfunction

    // ************************************
    // one request, held up to its taking edge
    // ************************************
    task automatic access(input logic wr, input logic [7:0] addr,
        input logic [31:0] wd, output logic [31:0] rd, output logic hit,
        output logic rdy);
        @(posedge clk_sys);
        #1;
        ap_req   = 1'b1;
        ap_write = wr;
        ap_addr  = addr;
        ap_wdata = wd;
        @(posedge clk_sys);
        #1;
        // a miss is handed back, never fatal
        rd  = ap_rdata;
        hit = ap_hit;
        rdy = ap_ready;
        // released lines show no stale value
        ap_req   = 1'b0;
        ap_write = ~wr;
        ap_addr  = ~addr;
        ap_wdata = ~wd;
    endtask
endmodule

/* verification/dbgptr_monitor.sv */
/*
 * Checker of the pointer bank ports: request answers, decoding and the
 * pointer word layout.
 * Assumes it is bound onto the bank and sees only its ports.
 */
`timescale 1ns/1ps

module dbgptr_monitor
    import dbgptr_pkg::*;
#(
    parameter bit LARGE_ADDR = 1'b0,
    parameter bit LEGACY_FMT = 1'b0
)
(
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    // register requests and answers
    input wire logic                 ap_req,
    input wire logic                 ap_write,
    input wire logic [AP_ADDR_W-1:0] ap_addr,
    input wire logic                 ap_ready,
    input wire logic                 ap_hit,
    input wire logic [WORD_W-1:0]    ap_rdata,
    // pointer status
    input wire logic                 ptr_valid,
    input wire logic                 ptr_nonsecure,
    input wire logic [WORD_W-1:0]    ptr_word_low,
    input wire logic [WORD_W-1:0]    ptr_word_high,
    input wire logic [PROT_W-1:0]    csw_prot_default,
    input wire logic [TYPE_W-1:0]    csw_type_default
);
    // ************************************
    // decode; address bits 1:0 never matter
    // ************************************
    wire logic at_low  = ap_addr[7:2] == PTR_LOW_OFFSET[7:2];
    wire logic at_high = ap_addr[7:2] == PTR_HIGH_OFFSET[7:2];
    wire logic rd_req  = ap_req && !ap_write;
    wire logic cur_fmt = !(LEGACY_FMT && !LARGE_ADDR);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // answers and contents
    a_ready_one_cycle: assert property (ap_req |=> ap_ready)
        else $error("request not answered next cycle");
    a_ready_no_req: assert property (!ap_req |=> !ap_ready)
        else $error("answer without request");
    a_hit_decode: assert property (ap_req && (at_low || at_high) |=> ap_hit)
        else $error("pointer location not hit");
    a_miss_zero: assert property (ap_req && !at_low && !at_high
        |=> !ap_hit && ap_rdata == '0) else $error("unmapped access answered");
    a_write_no_data: assert property (ap_req && ap_write |=> ap_rdata == '0)
        else $error("write returned data");
    a_low_word_read: assert property (rd_req && at_low && ptr_valid
        |=> ap_rdata == ptr_word_low) else $error("low word read wrong");
    a_high_word_read: assert property (rd_req && at_high && ptr_valid
        |=> ap_rdata == (LARGE_ADDR ? ptr_word_high : '0))
        else $error("high word read wrong");
    a_word_layout: assert property (ptr_valid && cur_fmt
        |-> ptr_word_low[11:1] == 11'h001) else $error("low word layout bits");
    a_words_static: assert property (ptr_valid && $past(ptr_valid)
        |-> $stable(ptr_word_low) && $stable(ptr_word_high))
        else $error("pointer words changed");
    a_load_time: assert property ($rose(reset_n) |-> ##[2:3] ptr_valid)
        else $error("pointer not loaded in time");
    a_attr_consts: assert property (ptr_nonsecure
        && csw_prot_default == CSW_PROT_RESET && csw_type_default == CSW_TYPE_RESET)
        else $error("attribute defaults wrong");
endmodule
